// File: logic/ccw_pkg.sv
// shared constants and types of the core-side cache, buffer and tight memory block
package ccw_pkg;
  // ==========================================================
  // geometry
  localparam int LINE_WORDS = 8;
  localparam int WAYS = 4;
  localparam int CACHE_BYTES = 16384;
  localparam int SETS = CACHE_BYTES / (WAYS * LINE_WORDS * 4);
  localparam int LINES = WAYS * SETS;
  localparam int WBUF_ADDRS = 4;
  localparam int WBUF_WORDS = 16;
  localparam int ENTRY_WORDS = WBUF_WORDS / WBUF_ADDRS;
  localparam int TIGHT_MAX_BYTES = 65536;
  // ==========================================================
  // register word indices (byte address = 4 * index)
  localparam logic [5:0] IDX_CTRL = 6'h01;
  localparam logic [5:0] IDX_DACR = 6'h03;
  localparam logic [5:0] IDX_DFSR = 6'h05;
  localparam logic [5:0] IDX_FAR = 6'h06;
  localparam logic [5:0] IDX_CACHEOP = 6'h07;
  localparam logic [5:0] IDX_DTIGHT = 6'h09;
  localparam logic [5:0] IDX_IFSR = 6'h10;
  localparam logic [5:0] IDX_ITIGHT = 6'h11;
  // ==========================================================
  // control bits and reset values
  localparam int CTL_MMU = 0;
  localparam int CTL_ALIGN = 1;
  localparam int CTL_DC = 2;
  localparam int CTL_IC = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] DACR_RST = 32'h0000_0000;
  localparam logic [31:0] RGN_RST = 32'h0000_0000;
  localparam logic [7:0] FSR_RST = 8'h00;
  // region register: [31:10] base, [5:2] size code, [0] enable
  localparam int RGN_EN = 0;
  localparam int RGN_SZ_LO = 2;
  localparam logic [3:0] RGN_SZ_MAX = 4'h7;
  localparam logic [4:0] RGN_SZ_SHIFT = 5'h09;
  // cache operation word: [0] clean, [11:5] set, [31:30] way
  localparam int COP_CLEAN = 0;
  // ==========================================================
  // fault status codes
  localparam logic [3:0] FS_NONE = 4'h0;
  localparam logic [3:0] FS_ALIGN = 4'h1;
  localparam logic [3:0] FS_XLATE = 4'h5;
  localparam logic [3:0] FS_DOMAIN = 4'h9;
  localparam logic [3:0] FS_PERM = 4'hd;
  // bus burst codes
  localparam logic [2:0] BURST_SINGLE = 3'h0;
  localparam logic [2:0] BURST_WRAP8 = 3'h4;
  localparam logic [2:0] BURST_INCR4 = 3'h3;
  localparam logic [2:0] BURST_INCR8 = 3'h5;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [31:0] pa;
    logic [3:0] domain;
    logic [1:0] ap;
    logic c;
    logic b;
  } ccw_xlat_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] size;
    logic priv;
    logic [31:0] vaddr;
    logic [31:0] wdata;
    ccw_xlat_t xlat;
  } ccw_req_t;
  typedef struct packed {
    logic done;
    logic abort;
    logic [31:0] rdata;
  } ccw_rsp_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [2:0] burst;
  } ccw_bus_req_t;
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
  } ccw_bus_rsp_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FILL = 2'b01,
    ST_SRD = 2'b10,
    ST_SWR = 2'b11
  } ccw_st_t;
  typedef struct packed {
    logic v;
    logic [26:0] line;
    logic [1:0] mask;
    logic [2:0] beat;
    logic [255:0] data;
  } ccw_wbb_t;
  typedef struct packed {
    logic [29:0] waddr;
    logic [2:0] cnt;
    logic [15:0] strb;
    logic [127:0] data;
  } ccw_wbe_t;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] dacr;
    logic [7:0] dfsr;
    logic [7:0] ifsr;
    logic [31:0] far;
    logic [31:0] drgn;
    logic [31:0] irgn;
    logic ack;
    logic [31:0] rdata;
    ccw_st_t st;
    logic f_dc;
    logic [26:0] f_line;
    logic [2:0] f_start;
    logic [2:0] f_beat;
    logic [8:0] f_idx;
    logic [31:0] s_addr;
    logic [31:0] s_wdata;
    logic [3:0] s_strb;
    logic s_dport;
    logic [LINES-1:0] iv;
    logic [LINES-1:0] dv;
    logic [2*LINES-1:0] dd;
    logic [1:0] irr;
    logic [1:0] drr;
    ccw_wbb_t wbb;
    ccw_wbe_t [WBUF_ADDRS-1:0] ent;
    logic [1:0] wb_head;
    logic [1:0] wb_tail;
    logic [2:0] wb_num;
    logic [1:0] wb_beat;
    ccw_rsp_t if_rsp;
    ccw_rsp_t d_rsp;
  } ccw_state_t;
endpackage : ccw_pkg

// File: logic/ccw_core_mem.sv
// core-side fault capture, split caches, write-back buffer, write buffer and tight memories
// Contract
// R01: abort on alignment, translation, domain, permission faults
// R02: fault status keeps cause and domain
// R03: fault address keeps aborted data address
// R04: two 16 KB four-way caches, eight-word lines
// R05: read miss fetches critical word first, wraps
// R06: control bits enable or disable each cache
// R07: translation off: fetches cacheable, flat, unchecked
// R08: instruction cache off: every fetch on bus
// R09: reset invalidates and disables instruction cache
// R10: translation off: data uncached, unbuffered, on bus
// R11: aborted data access makes no bus traffic
// R12: data lines keep physical tag for write-back
// R13: two dirty halves decide write-back amount
// R14: descriptor c/b bits select write policy
// R15: write-back buffer: one address, eight words
// R16: write buffer: sixteen words, four addresses
// R17: write-through hit updates line and buffer
// R18: write-back hit only marks half dirty
// R19: write miss goes to write buffer
// R20: each tight memory sized 0 to 64 KB
// R21: software aligns bases, keeps regions apart
// R22: data port reaches instruction tight memory
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/100ps
module ccw_core_mem #(
  parameter int ITIGHT_BYTES = 65536,
  parameter int DTIGHT_BYTES = 65536
) (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire ccw_pkg::ccw_req_t i_freq,
  output ccw_pkg::ccw_rsp_t o_frsp,
  input wire ccw_pkg::ccw_req_t i_dreq,
  output ccw_pkg::ccw_rsp_t o_drsp,
  output ccw_pkg::ccw_bus_req_t o_bus,
  input wire ccw_pkg::ccw_bus_rsp_t i_bus,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  import ccw_pkg::*;
  localparam int IW = $clog2(ITIGHT_BYTES / 4);
  localparam int DW = $clog2(DTIGHT_BYTES / 4);

  // ==========================================================
  // storage arrays
  logic [31:0] ic_mem [LINES*LINE_WORDS];
  logic [19:0] ic_tag [LINES];
  logic [31:0] dc_mem [LINES*LINE_WORDS];
  logic [19:0] dc_vtag [LINES];
  logic [19:0] dc_ptag [LINES];
  logic [31:0] it_mem [ITIGHT_BYTES/4];
  logic [31:0] dt_mem [DTIGHT_BYTES/4];
  ccw_state_t q;
  ccw_state_t n;
  logic ic_we, ict_we, dc_we, dct_we, it_we, dt_we;
  logic [11:0] ic_wi, dc_wi;
  logic [8:0] ict_wi, dct_wi;
  logic [19:0] ict_wd, dcv_wd, dcp_wd;
  logic [31:0] ic_wd, dc_wd, t_wd;
  logic [31:0] t_wa;

  // ==========================================================
  // helpers
  function automatic logic tight_hit(input logic [31:0] rgn, input logic [31:0] pa);
    logic [3:0] sz;
    sz = rgn[RGN_SZ_LO +: 4];
    tight_hit = rgn[RGN_EN] && sz != 4'h0 && sz <= RGN_SZ_MAX &&
                (((pa ^ rgn) >> (RGN_SZ_SHIFT + {1'b0, sz})) == 32'h0); // [R20]
  endfunction : tight_hit

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? d[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : merge

  function automatic logic [3:0] fault_of(input ccw_xlat_t x, input logic [31:0] dacr,
                                          input logic priv, input logic wr,
                                          input logic mis);
    logic [1:0] dom;
    dom = dacr[{x.domain, 1'b0} +: 2];
    fault_of = FS_NONE;
    if (mis) begin
      fault_of = FS_ALIGN;
    end else if (!x.valid) begin
      fault_of = FS_XLATE;
    end else if (!dom[0]) begin
      fault_of = FS_DOMAIN;
    end else if (dom == 2'b01 && (x.ap == 2'b00 || (!priv && (x.ap == 2'b01 ||
                 (x.ap == 2'b10 && wr))))) begin
      fault_of = FS_PERM;
    end
  endfunction : fault_of

  // ==========================================================
  // next state
  always_comb begin
    ccw_xlat_t x;
    logic use_d, mis, go, fsm_bus, wbb_g, wb_g, ihit, dhit, itight, dtight;
    logic push, merge_ok, pop, ev_do, av_req;
    logic [1:0] ihw, dhw, last;
    logic [6:0] set;
    logic [19:0] vtag;
    logic [3:0] fcode, strb;
    logic [31:0] vaddr, wd;
    logic [8:0] ev_idx;
    logic [5:0] idx;
    x = '0;
    use_d = 1'b0;
    mis = 1'b0;
    go = 1'b0;
    ihit = 1'b0;
    dhit = 1'b0;
    ihw = 2'b00;
    dhw = 2'b00;
    push = 1'b0;
    pop = 1'b0;
    ev_do = 1'b0;
    ev_idx = 9'h000;
    fcode = FS_NONE;
    n = q;
    n.if_rsp.done = 1'b0;
    n.if_rsp.abort = 1'b0;
    n.d_rsp.done = 1'b0;
    n.d_rsp.abort = 1'b0;
    n.ack = 1'b0;
    {ic_we, ict_we, dc_we, dct_we, it_we, dt_we} = 6'h00;
    ic_wi = 12'h000;
    dc_wi = 12'h000;
    ict_wi = 9'h000;
    dct_wi = 9'h000;
    ict_wd = 20'h00000;
    dcv_wd = 20'h00000;
    dcp_wd = 20'h00000;
    ic_wd = 32'h0;
    dc_wd = 32'h0;
    t_wd = 32'h0;
    t_wa = 32'h0;
    idx = i_avs_address[7:2];
    av_req = i_avs_read || i_avs_write;
    // bus ownership: refill or single access first, then write-back buffer, then write buffer
    fsm_bus = q.st != ST_IDLE;
    wbb_g = !fsm_bus && q.wbb.v;
    wb_g = !fsm_bus && !q.wbb.v && q.wb_num != 3'h0;
    // selected core request and its translation
    use_d = i_dreq.valid && !q.d_rsp.done;
    vaddr = use_d ? i_dreq.vaddr : i_freq.vaddr;
    x = use_d ? i_dreq.xlat : i_freq.xlat;
    if (!q.ctrl[CTL_MMU]) begin
      x.valid = 1'b1;
      x.pa = vaddr; // [R07] [R10]
      x.c = !use_d; // [R07] [R10]
      x.b = 1'b0; // [R10]
    end
    if (use_d && q.ctrl[CTL_ALIGN]) begin
      mis = i_dreq.size == 2'h2 ? vaddr[1:0] != 2'h0 : (i_dreq.size == 2'h1 && vaddr[0]);
    end
    if (q.ctrl[CTL_MMU]) begin
      fcode = fault_of(x, q.dacr, use_d ? i_dreq.priv : i_freq.priv,
                       use_d && i_dreq.write, mis); // [R01]
    end else if (mis) begin
      fcode = FS_ALIGN; // [R01]
    end
    if (!use_d) begin
      x.c = x.c && q.ctrl[CTL_IC]; // [R06] [R08]
    end else begin
      x.c = x.c && q.ctrl[CTL_DC]; // [R06]
    end
    strb = i_dreq.size == 2'h2 ? 4'hf :
           i_dreq.size == 2'h1 ? (4'h3 << {vaddr[1], 1'b0}) : (4'h1 << vaddr[1:0]);
    set = vaddr[11:5];
    vtag = vaddr[31:12];
    for (int w = 0; w < WAYS; w++) begin
      if (q.iv[{2'(w), set}] && ic_tag[{2'(w), set}] == vtag) begin
        ihit = 1'b1;
        ihw = 2'(w);
      end
      if (q.dv[{2'(w), set}] && dc_vtag[{2'(w), set}] == vtag) begin
        dhit = 1'b1;
        dhw = 2'(w);
      end
    end
    itight = tight_hit(q.irgn, x.pa);
    dtight = use_d && tight_hit(q.drgn, x.pa);
    wd = merge(dc_mem[{dhw, set, vaddr[4:2]}], i_dreq.wdata, strb);
    // write buffer merge into last entry when it is not being drained
    last = q.wb_tail - 2'h1;
    merge_ok = q.wb_num != 3'h0 && q.ent[last].cnt < 3'(ENTRY_WORDS) &&
               q.ent[last].waddr + 30'(q.ent[last].cnt) == x.pa[31:2] &&
               !(last == q.wb_head && (q.wb_beat != 2'h0 || wb_g));
    // ========================================================
    // register slave
    if (av_req && !q.ack && q.st == ST_IDLE && !q.wbb.v && q.wb_num == 3'h0) begin
      n.ack = 1'b1;
      unique case (idx)
        IDX_CTRL: n.rdata = q.ctrl;
        IDX_DACR: n.rdata = q.dacr;
        IDX_DFSR: n.rdata = {24'h0, q.dfsr};
        IDX_IFSR: n.rdata = {24'h0, q.ifsr};
        IDX_FAR: n.rdata = q.far;
        IDX_DTIGHT: n.rdata = q.drgn;
        IDX_ITIGHT: n.rdata = q.irgn;
        default: n.rdata = 32'h0;
      endcase
    end
    if (q.ack && i_avs_write) begin
      unique case (idx)
        IDX_CTRL: n.ctrl = merge(q.ctrl, i_avs_writedata, i_avs_byteenable); // [R06]
        IDX_DACR: n.dacr = merge(q.dacr, i_avs_writedata, i_avs_byteenable);
        IDX_DFSR: n.dfsr = i_avs_byteenable[0] ? i_avs_writedata[7:0] : q.dfsr;
        IDX_IFSR: n.ifsr = i_avs_byteenable[0] ? i_avs_writedata[7:0] : q.ifsr;
        IDX_FAR: n.far = merge(q.far, i_avs_writedata, i_avs_byteenable);
        IDX_DTIGHT: n.drgn = merge(q.drgn, i_avs_writedata, i_avs_byteenable);
        IDX_ITIGHT: n.irgn = merge(q.irgn, i_avs_writedata, i_avs_byteenable);
        IDX_CACHEOP: begin
          ev_idx = {i_avs_writedata[31:30], i_avs_writedata[11:5]};
          ev_do = i_avs_writedata[COP_CLEAN] && q.dv[ev_idx]; // [R13]
        end
        default: ;
      endcase
    end
    // ========================================================
    // core request service
    go = (use_d || (i_freq.valid && !q.if_rsp.done)) && !av_req && !q.ack;
    unique case (q.st)
      ST_IDLE: begin
        if (go && fcode != FS_NONE) begin
          // aborted access never reaches a cache or the bus
          if (use_d) begin
            n.d_rsp.done = 1'b1; // [R11]
            n.d_rsp.abort = 1'b1; // [R01]
            n.dfsr = {x.domain, fcode}; // [R02]
            n.far = vaddr; // [R03]
          end else begin
            n.if_rsp.done = 1'b1;
            n.if_rsp.abort = 1'b1; // [R01]
            n.ifsr = {x.domain, fcode}; // [R02]
          end
        end else if (go && (itight || dtight)) begin
          t_wa = x.pa;
          if (use_d && i_dreq.write) begin
            t_wd = i_dreq.wdata;
            it_we = !dtight; // [R22]
            dt_we = dtight;
            n.d_rsp.done = 1'b1;
          end else if (use_d) begin
            n.d_rsp.done = 1'b1;
            n.d_rsp.rdata = dtight ? dt_mem[x.pa[DW+1:2]] : it_mem[x.pa[IW+1:2]]; // [R22]
          end else begin
            n.if_rsp.done = 1'b1;
            n.if_rsp.rdata = it_mem[x.pa[IW+1:2]];
          end
        end else if (go && !use_d && x.c && ihit) begin
          n.if_rsp.done = 1'b1;
          n.if_rsp.rdata = ic_mem[{ihw, set, vaddr[4:2]}];
        end else if (go && use_d && !i_dreq.write && x.c && dhit) begin
          n.d_rsp.done = 1'b1;
          n.d_rsp.rdata = dc_mem[{dhw, set, vaddr[4:2]}];
        end else if (go && use_d && i_dreq.write && (x.c || x.b)) begin
          push = (x.c && dhit && x.b) ? 1'b0 : 1'b1; // [R14] [R17] [R19]
          if (!push || merge_ok || q.wb_num < 3'(WBUF_ADDRS)) begin
            n.d_rsp.done = 1'b1; // [R16]
            if (x.c && dhit) begin
              dc_we = 1'b1;
              dc_wi = {dhw, set, vaddr[4:2]};
              dc_wd = wd; // [R17]
              n.dd[{dhw, set, vaddr[4]}] = x.b ? 1'b1 : q.dd[{dhw, set, vaddr[4]}]; // [R18]
            end
          end else begin
            push = 1'b0;
          end
        end else if (go && x.c && q.wb_num == 3'h0 && !q.wbb.v) begin
          // refill waits for both buffers so no stale line is read back
          n.st = ST_FILL;
          n.f_dc = use_d;
          n.f_line = x.pa[31:5];
          n.f_start = vaddr[4:2]; // [R05]
          n.f_beat = 3'h0;
          n.f_idx = {use_d ? q.drr : q.irr, set}; // [R04]
          if (use_d) begin
            ev_idx = {q.drr, set};
            ev_do = q.dv[ev_idx];
            n.dv[ev_idx] = 1'b0;
            dct_we = 1'b1;
            dct_wi = ev_idx;
            dcv_wd = vtag;
            dcp_wd = x.pa[31:12]; // [R12]
          end else begin
            n.iv[{q.irr, set}] = 1'b0;
            ict_we = 1'b1;
            ict_wi = {q.irr, set};
            ict_wd = vtag;
          end
        end else if (go && !x.c && q.wb_num == 3'h0 && !q.wbb.v) begin
          n.st = (use_d && i_dreq.write) ? ST_SWR : ST_SRD; // [R08] [R10]
          n.s_addr = x.pa;
          n.s_wdata = i_dreq.wdata;
          n.s_strb = use_d ? strb : 4'hf;
          n.s_dport = use_d;
        end
      end
      ST_FILL: begin
        if (i_bus.ready) begin
          n.f_beat = q.f_beat + 3'h1;
          if (q.f_dc) begin
            dc_we = 1'b1;
            dc_wi = {q.f_idx, q.f_start + q.f_beat};
            dc_wd = i_bus.rdata;
          end else begin
            ic_we = 1'b1;
            ic_wi = {q.f_idx, q.f_start + q.f_beat};
            ic_wd = i_bus.rdata;
          end
          if (q.f_beat == 3'h0) begin
            n.d_rsp.done = q.f_dc; // [R05]
            n.d_rsp.rdata = i_bus.rdata;
            n.if_rsp.done = !q.f_dc;
            n.if_rsp.rdata = i_bus.rdata;
          end
          if (q.f_beat == 3'(LINE_WORDS - 1)) begin
            n.st = ST_IDLE;
            if (q.f_dc) begin
              n.dv[q.f_idx] = 1'b1;
              n.drr = q.drr + 2'h1; // [R04]
            end else begin
              n.iv[q.f_idx] = 1'b1;
              n.irr = q.irr + 2'h1;
            end
          end
        end
      end
      ST_SRD, ST_SWR: begin
        if (i_bus.ready) begin
          n.st = ST_IDLE;
          n.d_rsp.done = q.s_dport;
          n.d_rsp.rdata = i_bus.rdata;
          n.if_rsp.done = !q.s_dport;
          n.if_rsp.rdata = i_bus.rdata;
        end
      end
    endcase
    // ========================================================
    // write-back buffer: dirty halves of an evicted or cleaned line
    if (wbb_g && i_bus.ready) begin
      n.wbb.beat = q.wbb.beat + 3'h1;
      n.wbb.v = !(q.wbb.beat == 3'h7 || (q.wbb.beat == 3'h3 && !q.wbb.mask[1])); // [R13]
    end
    if (ev_do && q.dd[{ev_idx, 1'b1}] | q.dd[{ev_idx, 1'b0}]) begin
      n.wbb.v = 1'b1; // [R15]
      n.wbb.line = {dc_ptag[ev_idx], ev_idx[6:0]}; // [R12]
      n.wbb.mask = {q.dd[{ev_idx, 1'b1}], q.dd[{ev_idx, 1'b0}]}; // [R13]
      n.wbb.beat = q.dd[{ev_idx, 1'b0}] ? 3'h0 : 3'h4;
      for (int k = 0; k < LINE_WORDS; k++) begin
        n.wbb.data[32*k +: 32] = dc_mem[{ev_idx, 3'(k)}];
      end
    end
    if (ev_do) begin
      n.dd[{ev_idx, 1'b1}] = 1'b0;
      n.dd[{ev_idx, 1'b0}] = 1'b0;
    end
    // ========================================================
    // write buffer: four addresses of up to four words each
    if (wb_g && i_bus.ready) begin
      n.wb_beat = q.wb_beat + 2'h1;
      pop = 3'(q.wb_beat) + 3'h1 == q.ent[q.wb_head].cnt;
      if (pop) begin
        n.wb_beat = 2'h0;
        n.wb_head = q.wb_head + 2'h1;
      end
    end
    if (push && merge_ok) begin
      n.ent[last].cnt = q.ent[last].cnt + 3'h1; // [R16]
      n.ent[last].data[32*q.ent[last].cnt[1:0] +: 32] = i_dreq.wdata;
      n.ent[last].strb[4*q.ent[last].cnt[1:0] +: 4] = strb;
    end else if (push) begin
      n.ent[q.wb_tail].waddr = x.pa[31:2]; // [R16]
      n.ent[q.wb_tail].cnt = 3'h1;
      n.ent[q.wb_tail].data = {96'h0, i_dreq.wdata};
      n.ent[q.wb_tail].strb = {12'h000, strb};
      n.wb_tail = q.wb_tail + 2'h1;
    end
    n.wb_num = q.wb_num + 3'(push && !merge_ok) - 3'(pop);
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
      q.ctrl <= CTRL_RST; // [R09]
      q.dacr <= DACR_RST;
      q.dfsr <= FSR_RST;
      q.ifsr <= FSR_RST;
      q.drgn <= RGN_RST;
      q.irgn <= RGN_RST;
      q.st <= ST_IDLE;
      q.iv <= '0; // [R09]
      q.dv <= '0;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // array write ports
  always_ff @(posedge i_core_clk) begin
    if (ic_we) begin
      ic_mem[ic_wi] <= ic_wd;
    end
    if (ict_we) begin
      ic_tag[ict_wi] <= ict_wd;
    end
    if (dc_we) begin
      dc_mem[dc_wi] <= dc_wd;
    end
    if (dct_we) begin
      dc_vtag[dct_wi] <= dcv_wd;
      dc_ptag[dct_wi] <= dcp_wd;
    end
    if (it_we) begin
      it_mem[t_wa[IW+1:2]] <= t_wd; // [R22]
    end
    if (dt_we) begin
      dt_mem[t_wa[DW+1:2]] <= t_wd;
    end
  end

  // ==========================================================
  // outputs
  always_comb begin
    o_bus = '0;
    if (q.st == ST_FILL) begin
      o_bus.valid = 1'b1;
      o_bus.addr = {q.f_line, q.f_start + q.f_beat, 2'b00}; // [R05]
      o_bus.burst = BURST_WRAP8;
    end else if (q.st != ST_IDLE) begin
      o_bus.valid = 1'b1;
      o_bus.write = q.st == ST_SWR;
      o_bus.addr = {q.s_addr[31:2], 2'b00};
      o_bus.wdata = q.s_wdata;
      o_bus.wstrb = q.st == ST_SWR ? q.s_strb : 4'h0;
      o_bus.burst = BURST_SINGLE;
    end else if (q.wbb.v) begin
      o_bus.valid = 1'b1;
      o_bus.write = 1'b1;
      o_bus.addr = {q.wbb.line, q.wbb.beat, 2'b00};
      o_bus.wdata = q.wbb.data[32*q.wbb.beat +: 32];
      o_bus.wstrb = 4'hf;
      o_bus.burst = q.wbb.mask == 2'b11 ? BURST_INCR8 : BURST_INCR4; // [R13]
    end else if (q.wb_num != 3'h0) begin
      o_bus.valid = 1'b1;
      o_bus.write = 1'b1;
      o_bus.addr = {q.ent[q.wb_head].waddr + 30'(q.wb_beat), 2'b00};
      o_bus.wdata = q.ent[q.wb_head].data[32*q.wb_beat +: 32];
      o_bus.wstrb = q.ent[q.wb_head].strb[4*q.wb_beat +: 4];
      o_bus.burst = q.ent[q.wb_head].cnt == 3'(ENTRY_WORDS) ? BURST_INCR4 : BURST_SINGLE;
    end
  end

  assign o_frsp = q.if_rsp;
  assign o_drsp = q.d_rsp;
  assign o_avs_readdata = q.rdata;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !q.ack;
endmodule : ccw_core_mem

// File: testbench/ccw_core_mem_properties.sv
// port checker of the core-side memory block
`timescale 1ns/100ps
module ccw_props (
  input logic i_core_clk,
  input logic i_rstn,
  input ccw_pkg::ccw_rsp_t o_frsp,
  input ccw_pkg::ccw_rsp_t o_drsp,
  input ccw_pkg::ccw_bus_req_t o_bus,
  input ccw_pkg::ccw_bus_rsp_t i_bus,
  input logic i_avs_read,
  input logic i_avs_write,
  input logic o_avs_waitrequest
);
  import ccw_pkg::*;
  // ==========
  // properties
  logic [2:0] beat_q;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) beat_q <= 3'h0;
    else if (o_bus.valid && i_bus.ready && o_bus.burst == BURST_WRAP8) beat_q <= beat_q + 3'h1;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_first;
    o_bus.valid && i_bus.ready && o_bus.burst == BURST_WRAP8 && beat_q == 3'h0;
  endsequence
  a_first_done: assert property (s_first |=> o_drsp.done || o_frsp.done)
    else $error("no done after first beat");
  a_bus_hold: assert property (o_bus.valid && !i_bus.ready |=> $stable(o_bus))
    else $error("bus changed before ready");
  a_read_kind: assert property (o_bus.valid && !o_bus.write |-> o_bus.burst inside {3'h0, 3'h4})
    else $error("bad read burst");
  a_write_kind: assert property (o_bus.valid && o_bus.write |-> o_bus.burst != BURST_WRAP8)
    else $error("bad write burst");
  a_abort_done: assert property (o_drsp.abort |-> o_drsp.done)
    else $error("abort without done");
  a_done_pulse: assert property (o_drsp.done |=> !o_drsp.done)
    else $error("done held");
  a_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("no wait cycle");
  a_wait_cause: assert property (o_avs_waitrequest |-> i_avs_read || i_avs_write)
    else $error("wait without request");
endmodule : ccw_props
bind ccw_core_mem ccw_props u_props (.i_core_clk, .i_rstn, .o_frsp, .o_drsp, .o_bus, .i_bus,
  .i_avs_read, .i_avs_write, .o_avs_waitrequest);

// File: testbench/ccw_bus_model.sv
// system bus partner answering beats promptly or slowly
`timescale 1ns/100ps
module ccw_bus_model (
  input logic i_core_clk,
  input logic i_rstn,
  input logic i_slow,
  input ccw_pkg::ccw_bus_req_t i_req,
  output ccw_pkg::ccw_bus_rsp_t o_rsp
);
  import ccw_pkg::*;
  // ==========
  // responder
  logic [1:0] wait_q;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_q <= 2'h0;
      o_rsp <= '0;
    end else begin
      o_rsp.ready <= 1'b0;
      o_rsp.rdata <= ~o_rsp.rdata;
      wait_q <= i_req.valid ? wait_q + 2'h1 : 2'h0;
      if (i_req.valid && !o_rsp.ready && (!i_slow || wait_q == 2'h3)) begin
        o_rsp.ready <= 1'b1;
        o_rsp.rdata <= {i_req.addr[15:0], ~i_req.addr[15:0]};
      end
    end
  end
endmodule : ccw_bus_model

// File: testbench/cpu_cache_wbuf_tcm_fault_tb.sv
// self-checking bench of the core-side memory block
`timescale 1ns/100ps
module cpu_cache_wbuf_tcm_fault_tb;
  import ccw_pkg::*;
  // ==========
  // bench
  logic i_core_clk = 0, i_rstn = 0, slow = 0, rd = 0, wr = 0, wt;
  logic [7:0] aa = 8'h00, lf = 8'h5a;
  logic [31:0] wd = 32'h0, rdd, got, a, b, c;
  logic [3:0] fc[4] = '{FS_ALIGN, FS_XLATE, FS_DOMAIN, FS_PERM};
  ccw_req_t fq = '0, dq = '0;
  ccw_rsp_t fr, dr, rs;
  ccw_bus_req_t bq;
  ccw_bus_rsp_t br;
  ccw_xlat_t x = '0;
  int mismatches = 0, total_checks = 0;
  logic [31:0] q[$];
  always #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (bq.valid && br.ready) q.push_back(bq.addr);
  ccw_core_mem #(.ITIGHT_BYTES(4096), .DTIGHT_BYTES(4096)) uut (.i_core_clk, .i_rstn,
    .i_freq(fq), .o_frsp(fr), .i_dreq(dq), .o_drsp(dr), .o_bus(bq), .i_bus(br),
    .i_avs_address(aa), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdd), .o_avs_waitrequest(wt));
  ccw_bus_model u_bus (.i_core_clk, .i_rstn, .i_slow(slow), .i_req(bq), .o_rsp(br));
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nx
  function automatic logic [31:0] mw(input logic [31:0] v);
    return {v[15:0], ~v[15:0]};
  endfunction : mw
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic avs(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_core_clk);
    aa <= ad;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge i_core_clk); while (wt !== 1'b0);
    got = rdd;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : avs
  task automatic core(input logic d, input logic w, input logic [31:0] v);
    ccw_req_t r;
    r = '{valid: 1'b1, write: w, size: 2'h2, priv: 1'b0, vaddr: v, wdata: ~v, xlat: x};
    @(posedge i_core_clk);
    if (d) dq <= r;
    else fq <= r;
    do @(posedge i_core_clk); while ((d ? dr.done : fr.done) !== 1'b1);
    rs = d ? dr : fr;
    dq.valid <= 1'b0;
    fq.valid <= 1'b0;
  endtask : core
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge i_core_clk);
    mismatches++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    avs(0, 8'h04, 0);
    chk("ctrl", 0, got);
    avs(0, 8'hfc, 0);
    chk("unmapped", 0, got);
    a = {16'h0, lf, 8'h00};
    core(0, 0, a);
    chk("fetch", mw(a), rs.rdata);
    chk("fetch addr", a, q[0]);
    chk("fetch beats", 1, q.size());
    avs(1, 8'h04, 32'h1004);
    avs(0, 8'h04, 0);
    chk("ctrl on", 32'h1004, got);
    repeat (2) begin
      q.delete();
      core(1, 0, a + 8);
      chk("data", mw(a + 8), rs.rdata);
      chk("data beats", 1, q.size());
    end
    $display("test uncached done");
    lf = nx(lf);
    b = {16'h1, lf, 8'h00};
    slow <= 1'b1;
    q.delete();
    core(0, 0, b + 20);
    chk("fill word", mw(b + 20), rs.rdata);
    for (int i = 0; i < 300 && q.size() < 8; i++) @(posedge i_core_clk);
    for (int i = 0; i < 8; i++) chk("fill order", b + 32'((i * 4 + 20) % 32), q[i]);
    core(0, 0, b + 4);
    chk("hit", mw(b + 4), rs.rdata);
    chk("hit beats", 8, q.size());
    q.delete();
    core(1, 1, b);
    for (int i = 0; i < 300 && q.size() < 1; i++) @(posedge i_core_clk);
    chk("store", b, q[0]);
    $display("test fill done");
    avs(1, 8'h0c, 32'h4);
    avs(1, 8'h04, 32'h1007);
    lf = nx(lf);
    for (int k = 0; k < 4; k++) begin
      c = {16'h2, lf, 8'h00} + (k == 0);
      x = '{valid: k != 1, pa: c, domain: 4'(k == 2 ? 2 : 1), ap: 2'(k == 3 ? 0 : 3), c: 1, b: 1};
      q.delete();
      core(1, 0, c);
      chk("abort", 1, rs.abort);
      chk("no beats", 0, q.size());
      avs(0, 8'h14, 0);
      chk("status", k == 1 ? FS_XLATE : {x.domain, fc[k]}, k == 1 ? got[3:0] : got);
      avs(0, 8'h18, 0);
      chk("fault addr", c, got);
    end
    x.ap = 2'h3;
    avs(1, 8'h44, 32'h2600d);
    core(1, 1, c);
    core(0, 0, c);
    chk("tight", ~c, rs.rdata);
    $display("test faults done");
    summarize();
  end
endmodule : cpu_cache_wbuf_tcm_fault_tb
